/* lg_global_tx_cfg.sv */
`timescale 1ns/1ps
module lg_global_tx_cfg import lg_pkg::*; (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// control port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// interrupt sources and pin
	input wire logic [3:0] chan_irq_req,
	output logic irq_out,
	output logic irq_oe,
	// global controls
	output logic soft_reset_pulse,
	output logic line_standard_select,
	output logic mon_rx_active,
	output logic mon_tx_active,
	output logic [1:0] mon_src_chan,
	// per-channel attenuator controls
	output logic [3:0] ja_in_tx,
	output logic [3:0] ja_in_rx,
	output logic [31:0] ja_depth_bits,
	output logic [3:0] atten_limit_mode_mode,
	output logic [39:0] ja_corner,
	// per-channel transmit controls
	output logic [3:0] tx_power_down,
	output logic [3:0] tx_invert,
	output logic [3:0] tx_sample_rise,
	output logic [3:0] tx_enc_zs,
	output logic [3:0] tx_enc_ami,
	output logic [3:0] tx_dual_rail
);
	logic [7:0] global_config_0_q;
	logic [7:0] global_config_1_q;
	logic [7:0] jitter_atten_config_q [LG_NUM_CH];
	logic [7:0] transmit_config_0_q [LG_NUM_CH];
	logic [7:0] rdata_d;
	logic [7:0] channel_irq_flags;
	logic soft_rst;
	logic [1:0] wr_chan;
	logic [3:0] mon_code;

	// channel index carried in the top address bits
	function automatic logic [1:0] chan_of(input logic [7:0] a);
		chan_of = a[LG_CH_MSB:LG_CH_LSB];
	endfunction

	// offset inside a channel's 40H window
	function automatic logic [5:0] ofs_of(input logic [7:0] a);
		ofs_of = a[LG_CH_LSB-1:0];
	endfunction

	assign soft_rst = reg_wr && (reg_addr == LG_ADDR_RST);
	assign wr_chan = chan_of(reg_addr);
	assign mon_code = global_config_1_q[LG_G1_MON_MSB:LG_G1_MON_LSB];

	// soft reset pulse toward the rest of the device
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			soft_reset_pulse <= 1'b0;
		end else begin
			soft_reset_pulse <= soft_rst;
		end
	end

	// global configuration registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			global_config_0_q <= LG_G0_RESET;
			global_config_1_q <= LG_G1_RESET;
		end else if (soft_rst) begin
			global_config_0_q <= LG_G0_RESET;
			global_config_1_q <= LG_G1_RESET;
		end else if (reg_wr) begin
			if (reg_addr == LG_ADDR_GLOBAL_CONFIG_0) begin
				global_config_0_q <= reg_wdata & LG_G0_MASK;
			end
			if (reg_addr == LG_ADDR_GLOBAL_CONFIG_1) begin
				global_config_1_q <= reg_wdata & LG_G1_MASK;
			end
		end
	end

	// per-channel registers with optional broadcast
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < LG_NUM_CH; i++) begin
				jitter_atten_config_q[i] <= LG_JA_RESET;
				transmit_config_0_q[i] <= LG_TX_RESET;
			end
		end else if (soft_rst) begin
			for (int i = 0; i < LG_NUM_CH; i++) begin
				jitter_atten_config_q[i] <= LG_JA_RESET;
				transmit_config_0_q[i] <= LG_TX_RESET;
			end
		end else if (reg_wr) begin
			for (int i = 0; i < LG_NUM_CH; i++) begin
				if (global_config_0_q[LG_G0_BCAST] || (wr_chan == 2'(i))) begin
					if (ofs_of(reg_addr) == LG_OFS_JITTER_ATTEN_CONFIG) begin
						jitter_atten_config_q[i] <= reg_wdata & LG_JA_MASK;
					end
					if (ofs_of(reg_addr) == LG_OFS_TRANSMIT_CONFIG_0) begin
						transmit_config_0_q[i] <= reg_wdata & LG_TX_MASK;
					end
				end
			end
		end
	end

	// read multiplexer; unmapped addresses read zero
	always_comb begin
		rdata_d = 8'h00;
		if (reg_addr == LG_ADDR_GLOBAL_CONFIG_0) begin
			rdata_d = global_config_0_q;
		end else if (reg_addr == LG_ADDR_GLOBAL_CONFIG_1) begin
			rdata_d = global_config_1_q;
		end else if (reg_addr == LG_ADDR_INTERRUPT_CHANNEL_FLAGS) begin
			rdata_d = channel_irq_flags;
		end else if (ofs_of(reg_addr) == LG_OFS_JITTER_ATTEN_CONFIG) begin
			rdata_d = jitter_atten_config_q[chan_of(reg_addr)];
		end else if (ofs_of(reg_addr) == LG_OFS_TRANSMIT_CONFIG_0) begin
			rdata_d = transmit_config_0_q[chan_of(reg_addr)];
		end
	end

	// read data held until the next read
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rdata_d;
			end
		end
	end

	// line standard for all channels
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			line_standard_select <= 1'b0;
		end else begin
			line_standard_select <= global_config_0_q[LG_G0_LINE_STD];
		end
	end

	// monitor routing; reserved codes monitor nothing
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mon_rx_active <= 1'b0;
			mon_tx_active <= 1'b0;
			mon_src_chan <= 2'b00;
		end else begin
			mon_rx_active <= 1'b0;
			mon_tx_active <= 1'b0;
			mon_src_chan <= 2'b00;
			unique case (mon_code)
				LG_MON_RX2, LG_MON_RX3, LG_MON_RX4: begin
					mon_rx_active <= 1'b1;
					mon_src_chan <= mon_code[2:1];
				end
				LG_MON_TX2, LG_MON_TX3, LG_MON_TX4: begin
					mon_tx_active <= 1'b1;
					mon_src_chan <= mon_code[2:1];
				end
				default: begin
					mon_src_chan <= 2'b00;
				end
			endcase
		end
	end

	// interrupt pin and channel flags
	lg_irq_out u_irq (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.soft_rst(soft_rst),
		.chan_irq_req(chan_irq_req),
		.global_irq_disable(global_config_0_q[LG_G0_IRQ_DIS]),
		.pin_style(global_config_0_q[LG_G0_PIN_MSB:LG_G0_PIN_LSB]),
		.channel_irq_flags(channel_irq_flags),
		.irq_out(irq_out),
		.irq_oe(irq_oe)
	);

	// one field decoder per channel
	for (genvar g = 0; g < LG_NUM_CH; g++) begin : g_chan
		lg_chan_decode u_dec (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.ja_cfg(jitter_atten_config_q[g]),
			.tx_cfg(transmit_config_0_q[g]),
			.line_t1(global_config_0_q[LG_G0_LINE_STD]),
			.ja_in_tx(ja_in_tx[g]),
			.ja_in_rx(ja_in_rx[g]),
			.ja_depth_bits(ja_depth_bits[8*g +: 8]),
			.atten_limit_mode_mode(atten_limit_mode_mode[g]),
			.ja_corner(ja_corner[10*g +: 10]),
			.tx_power_down(tx_power_down[g]),
			.tx_invert(tx_invert[g]),
			.tx_sample_rise(tx_sample_rise[g]),
			.tx_enc_zs(tx_enc_zs[g]),
			.tx_enc_ami(tx_enc_ami[g]),
			.tx_dual_rail(tx_dual_rail[g])
		);
	end
endmodule

/* lg_pkg.sv */
package lg_pkg;

	// global register addresses
	localparam logic [7:0] LG_ADDR_RST = 8'h20;
	localparam logic [7:0] LG_ADDR_GLOBAL_CONFIG_0 = 8'h40;
	localparam logic [7:0] LG_ADDR_GLOBAL_CONFIG_1 = 8'h60;
	localparam logic [7:0] LG_ADDR_INTERRUPT_CHANNEL_FLAGS = 8'h80;

	// per-channel offsets; address bits 7:6 pick the channel (stride 40H)
	localparam logic [5:0] LG_OFS_JITTER_ATTEN_CONFIG = 6'h01;
	localparam logic [5:0] LG_OFS_TRANSMIT_CONFIG_0 = 6'h02;
	localparam int LG_CH_MSB = 7;
	localparam int LG_CH_LSB = 6;
	localparam int LG_NUM_CH = 4;

	// global_config_0 layout
	localparam int LG_G0_RSV5 = 5;
	localparam int LG_G0_LINE_STD = 4;
	localparam int LG_G0_BCAST = 3;
	localparam int LG_G0_IRQ_DIS = 2;
	localparam int LG_G0_PIN_MSB = 1;
	localparam int LG_G0_PIN_LSB = 0;
	localparam logic [7:0] LG_G0_MASK = 8'h3F;
	localparam logic [7:0] LG_G0_RESET = 8'h04;

	// global_config_1 layout
	localparam int LG_G1_MON_MSB = 7;
	localparam int LG_G1_MON_LSB = 4;
	localparam logic [7:0] LG_G1_MASK = 8'hF0;
	localparam logic [7:0] LG_G1_RESET = 8'h00;

	// interrupt_channel_flags: channel n at bit 2n
	localparam logic [7:0] LG_INTERRUPT_CHANNEL_FLAGS_RESET = 8'h00;

	// jitter_atten_config layout
	localparam int LG_ATTEN_LIMIT_MODE = 5;
	localparam int LG_JA_PLACE_MSB = 4;
	localparam int LG_JA_PLACE_LSB = 3;
	localparam int LG_JA_DEPTH_MSB = 2;
	localparam int LG_JA_DEPTH_LSB = 1;
	localparam int LG_JA_BW = 0;
	localparam logic [7:0] LG_JA_MASK = 8'h3F;
	localparam logic [7:0] LG_JA_RESET = 8'h00;

	// transmit_config_0 layout
	localparam int LG_TX_OFF = 4;
	localparam int LG_TX_INV = 3;
	localparam int LG_TX_EDGE = 2;
	localparam int LG_TX_MD_MSB = 1;
	localparam int LG_TX_MD_LSB = 0;
	localparam logic [7:0] LG_TX_MASK = 8'h1F;
	localparam logic [7:0] LG_TX_RESET = 8'h00;

	// elastic buffer depths in bits
	localparam logic [7:0] LG_DEPTH_128 = 8'h80;
	localparam logic [7:0] LG_DEPTH_64 = 8'h40;
	localparam logic [7:0] LG_DEPTH_32 = 8'h20;

	// attenuator corner frequencies in units of 0.01 Hz
	localparam logic [9:0] LG_CORNER_T1_WIDE = 10'h1F4;
	localparam logic [9:0] LG_CORNER_E1_WIDE = 10'h2A8;
	localparam logic [9:0] LG_CORNER_T1_NARROW = 10'h07D;
	localparam logic [9:0] LG_CORNER_E1_NARROW = 10'h05A;

	typedef enum logic [1:0] {
		LG_JA_OFF0 = 2'b00,
		LG_JA_TX = 2'b01,
		LG_JA_OFF1 = 2'b10,
		LG_JA_RX = 2'b11
	} lg_ja_place_e;

	typedef enum logic [1:0] {
		LG_TXM_B8ZS_HDB3 = 2'b00,
		LG_TXM_AMI = 2'b01,
		LG_TXM_DUAL0 = 2'b10,
		LG_TXM_DUAL1 = 2'b11
	} lg_tx_mode_e;

	// monitor select codes that carry meaning; odd codes are reserved
	localparam logic [3:0] LG_MON_RX_NONE = 4'h0;
	localparam logic [3:0] LG_MON_RX2 = 4'h2;
	localparam logic [3:0] LG_MON_RX3 = 4'h4;
	localparam logic [3:0] LG_MON_RX4 = 4'h6;
	localparam logic [3:0] LG_MON_TX_NONE = 4'h8;
	localparam logic [3:0] LG_MON_TX2 = 4'hA;
	localparam logic [3:0] LG_MON_TX3 = 4'hC;
	localparam logic [3:0] LG_MON_TX4 = 4'hE;

endpackage

/* lg_chan_decode.sv */
`timescale 1ns/1ps
module lg_chan_decode import lg_pkg::*; (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// stored configuration
	input wire logic [7:0] ja_cfg,
	input wire logic [7:0] tx_cfg,
	input wire logic line_t1,
	// decoded controls
	output logic ja_in_tx,
	output logic ja_in_rx,
	output logic [7:0] ja_depth_bits,
	output logic atten_limit_mode_mode,
	output logic [9:0] ja_corner,
	output logic tx_power_down,
	output logic tx_invert,
	output logic tx_sample_rise,
	output logic tx_enc_zs,
	output logic tx_enc_ami,
	output logic tx_dual_rail
);
	lg_ja_place_e place;
	lg_tx_mode_e mode;

	assign place = lg_ja_place_e'(ja_cfg[LG_JA_PLACE_MSB:LG_JA_PLACE_LSB]);
	assign mode = lg_tx_mode_e'(tx_cfg[LG_TX_MD_MSB:LG_TX_MD_LSB]);

	// attenuator placement, depth, limit and corner
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ja_in_tx <= 1'b0;
			ja_in_rx <= 1'b0;
			ja_depth_bits <= LG_DEPTH_128;
			atten_limit_mode_mode <= 1'b0;
			ja_corner <= LG_CORNER_E1_WIDE;
		end else begin
			ja_in_tx <= (place == LG_JA_TX);
			ja_in_rx <= (place == LG_JA_RX);
			unique case (ja_cfg[LG_JA_DEPTH_MSB:LG_JA_DEPTH_LSB])
				2'b00: ja_depth_bits <= LG_DEPTH_128;
				2'b01: ja_depth_bits <= LG_DEPTH_64;
				2'b10, 2'b11: ja_depth_bits <= LG_DEPTH_32;
			endcase
			atten_limit_mode_mode <= ja_cfg[LG_ATTEN_LIMIT_MODE];
			if (ja_cfg[LG_JA_BW]) begin
				ja_corner <= line_t1 ? LG_CORNER_T1_NARROW : LG_CORNER_E1_NARROW;
			end else begin
				ja_corner <= line_t1 ? LG_CORNER_T1_WIDE : LG_CORNER_E1_WIDE;
			end
		end
	end

	// transmit path controls
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_power_down <= 1'b0;
			tx_invert <= 1'b0;
			tx_sample_rise <= 1'b0;
			tx_enc_zs <= 1'b1;
			tx_enc_ami <= 1'b0;
			tx_dual_rail <= 1'b0;
		end else begin
			tx_power_down <= tx_cfg[LG_TX_OFF];
			tx_invert <= tx_cfg[LG_TX_INV];
			tx_sample_rise <= tx_cfg[LG_TX_EDGE];
			tx_enc_zs <= (mode == LG_TXM_B8ZS_HDB3);
			tx_enc_ami <= (mode == LG_TXM_AMI);
			tx_dual_rail <= (mode == LG_TXM_DUAL0) || (mode == LG_TXM_DUAL1);
		end
	end
endmodule

/* lg_irq_out.sv */
`timescale 1ns/1ps
module lg_irq_out import lg_pkg::*; (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic soft_rst,
	// per-channel requests, already gated by their own masks
	input wire logic [3:0] chan_irq_req,
	input wire logic global_irq_disable,
	input wire logic [1:0] pin_style,
	// results
	output logic [7:0] channel_irq_flags,
	output logic irq_out,
	output logic irq_oe
);
	logic any_irq;

	assign any_irq = (|chan_irq_req) && !global_irq_disable;

	// channel n flag at bit 2n
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			channel_irq_flags <= LG_INTERRUPT_CHANNEL_FLAGS_RESET;
		end else if (soft_rst) begin
			channel_irq_flags <= LG_INTERRUPT_CHANNEL_FLAGS_RESET;
		end else begin
			for (int i = 0; i < LG_NUM_CH; i++) begin
				channel_irq_flags[2*i] <= chan_irq_req[i];
				channel_irq_flags[2*i+1] <= 1'b0;
			end
		end
	end

	// pin drive; open drain only pulls low while asserted
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_out <= 1'b0;
			irq_oe <= 1'b0;
		end else begin
			if (!pin_style[0]) begin
				irq_out <= 1'b0;
				irq_oe <= any_irq;
			end else if (!pin_style[1]) begin
				irq_out <= !any_irq;
				irq_oe <= 1'b1;
			end else begin
				irq_out <= any_irq;
				irq_oe <= 1'b1;
			end
		end
	end
endmodule

/* lg_cfg_checker.sv */
`timescale 1ns/1ps
module lg_cfg_checker (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// control port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	// decoded outputs
	input wire logic soft_reset_pulse,
	input wire logic line_standard_select,
	input wire logic mon_tx_active,
	input wire logic [31:0] ja_depth_bits,
	input wire logic [3:0] tx_power_down,
	input wire logic [3:0] tx_dual_rail
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	property p_line;
		reg_wr && reg_addr == 8'h40 |-> ##2 line_standard_select == $past(reg_wdata[4], 2);
	endproperty
	a_line: assert property (p_line) else $error("line standard wrong");
	property p_off;
		reg_wr && reg_addr[5:0] == 6'h02
			|-> ##2 tx_power_down[$past(reg_addr[7:6], 2)] == $past(reg_wdata[4], 2);
	endproperty
	a_off: assert property (p_off) else $error("power down wrong");
	property p_dual;
		reg_wr && reg_addr[5:0] == 6'h02
			|-> ##2 tx_dual_rail[$past(reg_addr[7:6], 2)] == $past(reg_wdata[1], 2);
	endproperty
	a_dual: assert property (p_dual) else $error("dual rail wrong");
	property p_depth;
		reg_wr && reg_addr[5:0] == 6'h01 |-> ##2 ja_depth_bits[{$past(reg_addr[7:6], 2), 3'b000} +: 8]
			== ($past(reg_wdata[2], 2) ? 8'h20 : $past(reg_wdata[1], 2) ? 8'h40 : 8'h80);
	endproperty
	a_depth: assert property (p_depth) else $error("depth wrong");
	property p_mon;
		reg_wr && reg_addr == 8'h60
			|-> ##2 mon_tx_active == ($past(reg_wdata[7:4], 2) inside {4'hA, 4'hC, 4'hE});
	endproperty
	a_mon: assert property (p_mon) else $error("monitor wrong");
	property p_unmap;
		reg_rd && reg_addr == 8'hA0 |=> reg_rvalid && reg_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read wrong");
	property p_flags;
		reg_rd && reg_addr == 8'h80 |=> reg_rvalid && (reg_rdata & 8'hAA) == 8'h00;
	endproperty
	a_flags: assert property (p_flags) else $error("flag bits wrong");
	property p_srst;
		reg_wr && reg_addr == 8'h20
			|=> soft_reset_pulse ##1 (!line_standard_select && tx_power_down == 4'h0);
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset wrong");
	// main scenarios
	c_srst: cover property (soft_reset_pulse);
	c_mon: cover property (mon_tx_active);
	c_read: cover property (reg_rvalid);
endmodule

bind lg_global_tx_cfg lg_cfg_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .soft_reset_pulse(soft_reset_pulse),
	.line_standard_select(line_standard_select), .mon_tx_active(mon_tx_active),
	.ja_depth_bits(ja_depth_bits), .tx_power_down(tx_power_down), .tx_dual_rail(tx_dual_rail));

/* lg_host_model.sv */
`timescale 1ns/1ps
module lg_host_model (
	// clock
	input wire logic clk_sys,
	// control port
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	// idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// one write held across one rising edge, then lines scrambled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = (a == 8'h40) ? (d & 8'hDF) : d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~reg_wdata;
	endtask
	// one read; answer awaited under a bound
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		int i;
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		reg_addr = ~a;
		for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(negedge clk_sys);
		ok = (reg_rvalid === 1'b1);
		d = reg_rdata;
	endtask
endmodule

/* lg_global_tx_cfg_tb_top.sv */
`timescale 1ns/1ps
module lg_global_tx_cfg_tb_top import lg_pkg::*;;
	logic clk_sys, rst_n, reg_wr, reg_rd, reg_rvalid, irq_out, irq_oe, soft_reset_pulse;
	logic line_standard_select, mon_rx_active, mon_tx_active, ok;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv;
	logic [3:0] chan_irq_req, ja_in_tx, ja_in_rx, atten_limit_mode_mode, tx_power_down, tx_invert;
	logic [3:0] tx_sample_rise, tx_enc_zs, tx_enc_ami, tx_dual_rail;
	logic [1:0] mon_src_chan;
	logic [31:0] ja_depth_bits;
	logic [39:0] ja_corner;
	int mismatches, total_checks;
	// clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	lg_global_tx_cfg dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .chan_irq_req(chan_irq_req), .irq_out(irq_out),
		.irq_oe(irq_oe), .soft_reset_pulse(soft_reset_pulse),
		.line_standard_select(line_standard_select), .mon_rx_active(mon_rx_active),
		.mon_tx_active(mon_tx_active), .mon_src_chan(mon_src_chan), .ja_in_tx(ja_in_tx),
		.ja_in_rx(ja_in_rx), .ja_depth_bits(ja_depth_bits), .atten_limit_mode_mode(atten_limit_mode_mode),
		.ja_corner(ja_corner), .tx_power_down(tx_power_down), .tx_invert(tx_invert),
		.tx_sample_rise(tx_sample_rise), .tx_enc_zs(tx_enc_zs), .tx_enc_ami(tx_enc_ami),
		.tx_dual_rail(tx_dual_rail));
	lg_host_model hm (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	// verdict and end of run
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %0h seen %0h", n, e, g);
		end
	endtask
	// read one register and compare
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		hm.rd(a, rdv, ok);
		if (ok !== 1'b1) begin
			mismatches++;
			$display("Error reg_rvalid expected 1 seen %b", ok);
			test_done();
		end
		chk("rdata", {32'h0, e}, {32'h0, rdv});
	endtask
	// expectations
	function automatic logic [5:0] tx_exp(input logic [7:0] d);
		return {d[4], d[3], d[2], d[1:0] == 2'b00, d[1:0] == 2'b01, d[1]};
	endfunction
	function automatic logic [20:0] ja_exp(input logic [7:0] d, input logic t1);
		logic [9:0] cr;
		cr = d[0] ? (t1 ? LG_CORNER_T1_NARROW : LG_CORNER_E1_NARROW)
			: (t1 ? LG_CORNER_T1_WIDE : LG_CORNER_E1_WIDE);
		return {d[4:3] == 2'b01, d[4:3] == 2'b11, d[5], d[2] ? 8'h20 : d[1] ? 8'h40 : 8'h80, cr};
	endfunction
	function automatic logic [3:0] mon_exp(input logic [3:0] c);
		logic rx, tx;
		rx = c inside {4'h2, 4'h4, 4'h6};
		tx = c inside {4'hA, 4'hC, 4'hE};
		return {rx, tx, (rx || tx) ? c[2:1] : 2'b00};
	endfunction
	function automatic logic [1:0] irq_exp(input logic [3:0] r, input logic dis, input logic [1:0] s);
		return (|r && !dis) ? {s == 2'b11, 1'b1} : {s == 2'b01, s[0]};
	endfunction
	// watchdog
	initial begin
		repeat (20000) @(posedge clk_sys);
		mismatches++;
		$display("Error watchdog expected finish seen timeout");
		test_done();
	end
	// main sequence
	initial begin
		int i, c;
		logic [7:0] d, td, jd;
		logic [3:0] r;
		logic [1:0] m;
		rst_n = 1'b0;
		chan_irq_req = 4'h0;
		mismatches = 0;
		total_checks = 0;
		void'($urandom(5220));
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_n = 1'b1;
		rchk(8'h40, 8'h04);
		rchk(8'h60, 8'h00);
		rchk(8'h80, 8'h00);
		$display("test reset done");
		for (i = 0; i < 16; i++) begin
			m = i[3:2];
			c = i % 4;
			d = 8'($urandom);
			td = {d[7:2], m};
			jd = {d[7:5], m, m, d[0]};
			hm.wr(8'h40, {3'h0, d[6], 4'h4});
			hm.wr({i[1:0], 6'h02}, td);
			hm.wr({i[1:0], 6'h01}, jd);
			repeat (2) @(negedge clk_sys);
			chk("line", {39'h0, d[6]}, {39'h0, line_standard_select});
			chk("tx", {34'h0, tx_exp(td)}, {34'h0, tx_power_down[c], tx_invert[c],
				tx_sample_rise[c], tx_enc_zs[c], tx_enc_ami[c], tx_dual_rail[c]});
			chk("ja", {19'h0, ja_exp(jd, d[6])}, {19'h0, ja_in_tx[c], ja_in_rx[c], atten_limit_mode_mode[c],
				ja_depth_bits[8*c +: 8], ja_corner[10*c +: 10]});
			rchk({i[1:0], 6'h02}, td & 8'h1F);
			rchk({i[1:0], 6'h01}, jd & 8'h3F);
		end
		$display("test channel done");
		d = 8'($urandom);
		hm.wr(8'h40, 8'h0C);
		hm.wr(8'h82, d);
		hm.wr(8'h40, 8'h04);
		hm.wr(8'h02, ~d);
		for (i = 1; i < 4; i++) rchk({i[1:0], 6'h02}, d & 8'h1F);
		rchk(8'h02, ~d & 8'h1F);
		$display("test broadcast done");
		for (i = 0; i < 16; i++) begin
			hm.wr(8'h60, {i[3:0], 4'hF});
			repeat (2) @(negedge clk_sys);
			chk("mon", {36'h0, mon_exp(i[3:0])}, {36'h0, mon_rx_active, mon_tx_active,
				mon_src_chan});
			rchk(8'h60, {i[3:0], 4'h0});
		end
		$display("test monitor done");
		for (i = 0; i < 16; i++) begin
			r = 4'($urandom);
			chan_irq_req = i[0] ? ((r == 4'h0) ? 4'h8 : r) : 4'h0;
			hm.wr(8'h40, {5'h0, i[3], i[2:1]});
			repeat (2) @(negedge clk_sys);
			chk("pin", {38'h0, irq_exp(chan_irq_req, i[3], i[2:1])},
				{38'h0, irq_out, irq_oe});
			r = chan_irq_req;
			rchk(8'h80, {1'b0, r[3], 1'b0, r[2], 1'b0, r[1], 1'b0, r[0]});
		end
		chan_irq_req = 4'h0;
		$display("test interrupt done");
		hm.wr(8'h40, 8'h10);
		hm.wr(8'hC2, 8'h1F);
		hm.wr(8'h20, 8'($urandom));
		repeat (2) @(negedge clk_sys);
		chk("tx", {34'h0, tx_exp(8'h00)}, {34'h0, tx_power_down[3], tx_invert[3],
			tx_sample_rise[3], tx_enc_zs[3], tx_enc_ami[3], tx_dual_rail[3]});
		rchk(8'h40, 8'h04);
		rchk(8'hC2, 8'h00);
		rchk(8'h20, 8'h00);
		rchk(8'hA0, 8'h00);
		$display("test soft reset done");
		test_done();
	end
endmodule
